// File: core/pstc_prescaler.v
`timescale 1ns/1ps
`default_nettype none
module pstc_prescaler (
  input wire clk_i,
  input wire reset_n_i,
  input wire run_i,
  input wire [2:0] sel_i,
  output reg tick_o
);
  reg [5:0] count;
  reg [5:0] limit;
  always @* begin
    case (sel_i)
      3'h0: limit = 6'h00;
      3'h1: limit = 6'h01;
      3'h2: limit = 6'h03;
      3'h3: limit = 6'h07;
      3'h4: limit = 6'h0F;
      3'h5: limit = 6'h1F;
      3'h6: limit = 6'h3F;
      // reserved code treated as divide by one
      default: limit = 6'h00;
    endcase
  end
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= 6'h00;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      count <= 6'h00;
      tick_o <= 1'b0;
    end else if (count >= limit) begin
      count <= 6'h00;
      tick_o <= 1'b1;
    end else begin
      count <= count + 6'h01;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: core/pstc_top.v
// What this block does
// R1: a special event trigger sets the pending flag; hardware may also clear it.
// R2: interrupt request only while the special event interrupt enable is one.
// R3: immediate update loads active period at once, else at cycle boundary.
// R4: polarity bit makes sync input and output active-low when set.
// R5: sync output driven only while sync output enable is one.
// R6: external sync enable lets the chosen source reset the time base.
// R7: source 000 input one, 010 trigger output 16, 011 trigger output 17.
// R8: trigger fires every N-th compare match, N = postscale field plus one.
// R9: software changes settings only while the module is disabled.
// R10: with input one, period is programmed slightly above external period.
// R11: prescaler divides by 1,2,4,8,16,32,64; code 111 reserved.
// R12: software never changes the prescaler while the PWM runs.
// R13: 16-bit period register, reset value upper thirteen ones, lower three zeros.
// R14: count equal to compare value gives a match feeding the postscaler.
// R15: chop clock runs only while its enable bit is one.
// R16: chop frequency is prescaled clock over chop divider plus one.
// R17: 16-bit master duty value, reset zero, shared by generators.
// R18: unimplemented control, prescaler and chop bits ignore writes, read zero.
// R19: generator duty is master duty when master duty select is one.
// R20: master time base select routes the secondary time base to generators.
// R21: module enable bit turns the whole module on or off; sync output enable and duty outputs still follow their registers when off.
// R22: counter counts prescaled ticks, wraps after period, sync resets it.
// R23: pending flag stays until cleared, sets again only on next trigger.
`timescale 1ns/1ps
`default_nettype none
`include "pstc_defs.vh"
module pstc_top (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire [4:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O,
  input wire EXT_SYNC_INPUT_ONE_I,
  input wire TRIG_GEN_OUTPUT_16_I,
  input wire TRIG_GEN_OUTPUT_17_I,
  input wire PEND_CLEAR_I,
  input wire [15:0] GEN_DUTY_I,
  output reg SYNC_OUTPUT_TWO_O,
  output reg SYNC_OUTPUT_TWO_OE_N_O,
  output reg SPECIAL_EVENT_TRIG_O,
  output reg SPECIAL_EVENT_IRQ_O,
  output reg [15:0] MASTER_TIMEBASE_COUNTER_O,
  output reg TIMEBASE_TICK_O,
  output reg TIMEBASE_ROLLOVER_O,
  output reg CHOP_CLOCK_O,
  output reg [15:0] MASTER_DUTY_CYCLE_O,
  output reg [15:0] GEN_DUTY_SEL_O,
  output reg MASTER_TIMEBASE_SELECT_O,
  output reg PWM_MODULE_ENABLE_O
);
  reg [15:0] ctrl;
  reg [15:0] clkdiv;
  reg [15:0] period;
  reg [15:0] active_period;
  reg [15:0] compare;
  reg [15:0] chop;
  reg [15:0] mduty;
  reg [15:0] modctl;
  reg [15:0] count;
  reg [3:0] ps_count;
  reg [9:0] chop_count;
  reg period_dirty;
  reg sync_prev;
  reg bus_done;
  reg [15:0] rd_word;
  reg sync_raw;
  reg [15:0] wmask;
  reg [15:0] next_ctrl;
  wire [2:0] idx = AVS_ADDRESS_I[4:2];
  wire enable = modctl[`PSTC_MOD_EN];
  wire pol = ctrl[`PSTC_CTRL_POL];
  wire tick;
  wire bus_req = (AVS_READ_I | AVS_WRITE_I) & ~bus_done;
  wire wr = AVS_WRITE_I & ~bus_done;
  wire sync_act = sync_raw ^ pol; // R4
  wire sync_edge = sync_act & ~sync_prev & ctrl[`PSTC_CTRL_EXTERNAL_SYNC_ENABLE]; // R6
  wire at_end = count >= active_period;
  wire match = tick & (count == compare); // R14
  wire fire = match & (ps_count == ctrl[`PSTC_CTRL_PS_HI:`PSTC_CTRL_PS_LO]); // R8
  // one chop period spans divider + 1 ticks; high for the first half of it
  wire [10:0] chop_len = {1'b0, chop[9:0]} + 11'h001;
  wire [9:0] chop_half = chop_len[10:1];
  // shared tick: chop and counter both run off the prescaled clock
  pstc_prescaler u_pre (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .run_i(enable),
    .sel_i(clkdiv[2:0]),
    .tick_o(tick)
  ); // R11
  always @* begin
    case (ctrl[`PSTC_CTRL_SRC_HI:`PSTC_CTRL_SRC_LO]) // R7
      `PSTC_SRC_EXT1: sync_raw = EXT_SYNC_INPUT_ONE_I;
      `PSTC_SRC_TRIG16: sync_raw = TRIG_GEN_OUTPUT_16_I;
      `PSTC_SRC_TRIG17: sync_raw = TRIG_GEN_OUTPUT_17_I;
      // reserved codes hold the input idle, so no false edges appear
      default: sync_raw = pol;
    endcase
  end
  always @* begin
    wmask = {{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  end
  always @* begin
    case (idx)
      `PSTC_IDX_CTRL: rd_word = ctrl & `PSTC_CTRL_MASK; // R18
      `PSTC_IDX_CLKDIV: rd_word = clkdiv & `PSTC_CLKDIV_MASK;
      `PSTC_IDX_PERIOD: rd_word = period;
      `PSTC_IDX_COMPARE: rd_word = compare;
      `PSTC_IDX_CHOP: rd_word = chop & `PSTC_CHOP_MASK;
      `PSTC_IDX_MDUTY: rd_word = mduty;
      `PSTC_IDX_MODCTL: rd_word = modctl & `PSTC_MODCTL_MASK;
      default: rd_word = 16'h0000;
    endcase
  end
  // bus: one wait cycle, answer on the second edge of the request
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bus_done <= 1'b0;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0000_0000;
    end else begin
      bus_done <= bus_req;
      AVS_WAITREQUEST_O <= ~bus_req;
      if (AVS_READ_I & ~bus_done)
        AVS_READDATA_O <= {16'h0000, rd_word};
    end
  end
  // control register: pending flag set wins over any clear
  always @* begin
    next_ctrl = ctrl;
    if (wr && idx == `PSTC_IDX_CTRL)
      next_ctrl = ((ctrl & ~wmask) | (AVS_WRITEDATA_I[15:0] & wmask)) & `PSTC_CTRL_MASK; // R18
    // software may only clear pending, never set it
    next_ctrl[`PSTC_CTRL_PEND] = ctrl[`PSTC_CTRL_PEND]
                                 & ~(wr && idx == `PSTC_IDX_CTRL && wmask[12]
                                     && !AVS_WRITEDATA_I[12]); // R23
    if (PEND_CLEAR_I)
      next_ctrl[`PSTC_CTRL_PEND] = 1'b0; // R1
    if (fire)
      next_ctrl[`PSTC_CTRL_PEND] = 1'b1; // R1
  end
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl <= `PSTC_ZERO_RST;
      clkdiv <= `PSTC_ZERO_RST;
      period <= `PSTC_PERIOD_RST; // R13
      compare <= `PSTC_ZERO_RST;
      chop <= `PSTC_ZERO_RST;
      mduty <= `PSTC_ZERO_RST; // R17
      modctl <= `PSTC_ZERO_RST;
    end else begin
      ctrl <= next_ctrl;
      if (wr) begin
        case (idx)
          `PSTC_IDX_CLKDIV: clkdiv <= ((clkdiv & ~wmask) | (AVS_WRITEDATA_I[15:0] & wmask))
                                      & `PSTC_CLKDIV_MASK; // R18
          `PSTC_IDX_PERIOD: period <= (period & ~wmask) | (AVS_WRITEDATA_I[15:0] & wmask);
          `PSTC_IDX_COMPARE: compare <= (compare & ~wmask) | (AVS_WRITEDATA_I[15:0] & wmask);
          `PSTC_IDX_CHOP: chop <= ((chop & ~wmask) | (AVS_WRITEDATA_I[15:0] & wmask))
                                  & `PSTC_CHOP_MASK; // R18
          `PSTC_IDX_MDUTY: mduty <= (mduty & ~wmask) | (AVS_WRITEDATA_I[15:0] & wmask);
          `PSTC_IDX_MODCTL: modctl <= ((modctl & ~wmask) | (AVS_WRITEDATA_I[15:0] & wmask))
                                      & `PSTC_MODCTL_MASK;
          default: ;
        endcase
      end
    end
  end
  // active period and time base counter
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      active_period <= `PSTC_PERIOD_RST;
      period_dirty <= 1'b0;
      count <= 16'h0000;
      sync_prev <= 1'b0;
      ps_count <= 4'h0;
    end else begin
      sync_prev <= sync_act;
      if (ctrl[`PSTC_CTRL_IMMED]) begin
        active_period <= period; // R3
        period_dirty <= 1'b0;
      end else if (tick && (at_end || sync_edge)) begin
        active_period <= period; // R3
        period_dirty <= 1'b0;
      end else if (wr && idx == `PSTC_IDX_PERIOD) begin
        period_dirty <= 1'b1;
      end
      if (!enable) begin
        count <= 16'h0000; // R21
        ps_count <= 4'h0;
      end else begin
        if (sync_edge)
          count <= 16'h0000; // R22
        else if (tick)
          count <= at_end ? 16'h0000 : count + 16'h0001; // R22
        if (match)
          ps_count <= fire ? 4'h0 : ps_count + 4'h1; // R8
      end
    end
  end
  // chop clock: period of (divider + 1) prescaled ticks
  // divider 0 at divide-by-one cannot toggle faster than the clock: output stays high
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      chop_count <= 10'h000;
      CHOP_CLOCK_O <= 1'b0;
    end else if (!chop[`PSTC_CHOP_EN] || !enable) begin
      chop_count <= 10'h000; // R15
      CHOP_CLOCK_O <= 1'b0;
    end else if (tick) begin
      if (chop_count >= chop[9:0]) begin
        chop_count <= 10'h000; // R16
        CHOP_CLOCK_O <= 1'b1;
      end else begin
        chop_count <= chop_count + 10'h001;
        if (chop_count + 10'h001 == chop_half)
          CHOP_CLOCK_O <= 1'b0; // R16
      end
    end
  end
  // outputs to generators and trigger logic
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SYNC_OUTPUT_TWO_O <= 1'b0;
      SYNC_OUTPUT_TWO_OE_N_O <= 1'b1;
      SPECIAL_EVENT_TRIG_O <= 1'b0;
      SPECIAL_EVENT_IRQ_O <= 1'b0;
      MASTER_TIMEBASE_COUNTER_O <= 16'h0000;
      TIMEBASE_TICK_O <= 1'b0;
      TIMEBASE_ROLLOVER_O <= 1'b0;
      MASTER_DUTY_CYCLE_O <= 16'h0000;
      GEN_DUTY_SEL_O <= 16'h0000;
      MASTER_TIMEBASE_SELECT_O <= 1'b0;
      PWM_MODULE_ENABLE_O <= 1'b0;
    end else begin
      SYNC_OUTPUT_TWO_OE_N_O <= ~ctrl[`PSTC_CTRL_SOEN]; // R5
      SYNC_OUTPUT_TWO_O <= (ctrl[`PSTC_CTRL_SOEN] & enable & tick & at_end) ^ pol; // R4
      SPECIAL_EVENT_TRIG_O <= fire;
      SPECIAL_EVENT_IRQ_O <= fire & ctrl[`PSTC_CTRL_IRQEN]; // R2
      MASTER_TIMEBASE_COUNTER_O <= count;
      TIMEBASE_TICK_O <= tick & enable & modctl[`PSTC_MOD_MASTER_TIMEBASE_SELECT]; // R20
      TIMEBASE_ROLLOVER_O <= tick & enable & at_end;
      MASTER_DUTY_CYCLE_O <= mduty;
      GEN_DUTY_SEL_O <= modctl[`PSTC_MOD_MASTER_DUTY_SELECT] ? mduty : GEN_DUTY_I; // R19
      MASTER_TIMEBASE_SELECT_O <= modctl[`PSTC_MOD_MASTER_TIMEBASE_SELECT]; // R20
      PWM_MODULE_ENABLE_O <= enable; // R21
    end
  end
endmodule
`default_nettype wire

// File: inc/pstc_defs.vh
`ifndef PSTC_DEFS_VH
`define PSTC_DEFS_VH
// register word offsets (byte address = 4 * index)
`define PSTC_IDX_CTRL 3'h0
`define PSTC_IDX_CLKDIV 3'h1
`define PSTC_IDX_PERIOD 3'h2
`define PSTC_IDX_COMPARE 3'h3
`define PSTC_IDX_CHOP 3'h4
`define PSTC_IDX_MDUTY 3'h5
`define PSTC_IDX_MODCTL 3'h6
// control register fields
`define PSTC_CTRL_PEND 12
`define PSTC_CTRL_IRQEN 11
`define PSTC_CTRL_IMMED 10
`define PSTC_CTRL_POL 9
`define PSTC_CTRL_SOEN 8
`define PSTC_CTRL_EXTERNAL_SYNC_ENABLE 7
`define PSTC_CTRL_SRC_HI 6
`define PSTC_CTRL_SRC_LO 4
`define PSTC_CTRL_PS_HI 3
`define PSTC_CTRL_PS_LO 0
`define PSTC_CTRL_MASK 16'h1FFF
`define PSTC_CLKDIV_MASK 16'h0007
`define PSTC_CHOP_MASK 16'h83FF
`define PSTC_CHOP_EN 15
// module control fields
`define PSTC_MOD_EN 15
`define PSTC_MOD_MASTER_TIMEBASE_SELECT 3
`define PSTC_MOD_MASTER_DUTY_SELECT 8
`define PSTC_MODCTL_MASK 16'h8108
// sync source codes
`define PSTC_SRC_EXT1 3'h0
`define PSTC_SRC_TRIG16 3'h2
`define PSTC_SRC_TRIG17 3'h3
// reset values
`define PSTC_PERIOD_RST 16'hFFF8
`define PSTC_ZERO_RST 16'h0000
// sync output pulse length in cycles
`define PSTC_SYNC_PULSE 4'h1
`endif

// File: verification/pstc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module pstc_far_side (
  input wire logic clk_i,
  output logic [2:0] sync_o,
  output logic pend_clear_o,
  output logic [15:0] duty_o
);
  logic pol = 1'b0;
  initial begin
    sync_o = 3'h0;
    pend_clear_o = 1'b0;
    duty_o = 16'h0000;
  end
  // lines rest at the inactive level of the chosen polarity
  task automatic park(input logic p, input logic [15:0] d);
    @(posedge clk_i);
    pol = p;
    sync_o <= {3{p}};
    duty_o <= d;
  endtask
  task automatic fire(input int b);
    @(posedge clk_i);
    sync_o[b] <= ~pol;
    @(posedge clk_i);
    sync_o <= {3{pol}};
  endtask
  task automatic clr();
    @(posedge clk_i);
    pend_clear_o <= 1'b1;
    @(posedge clk_i);
    pend_clear_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verification/pstc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pstc_sva (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_READDATA_O,
  input wire AVS_WAITREQUEST_O,
  input wire SPECIAL_EVENT_TRIG_O,
  input wire SPECIAL_EVENT_IRQ_O,
  input wire SYNC_OUTPUT_TWO_OE_N_O,
  input wire [15:0] MASTER_TIMEBASE_COUNTER_O,
  input wire TIMEBASE_ROLLOVER_O,
  input wire [15:0] MASTER_DUTY_CYCLE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence req_s; $rose(AVS_READ_I || AVS_WRITE_I); endsequence
  // settings may only move once a bus write has landed
  sequence wrote_s; $past(AVS_WRITE_I) || $past(AVS_WRITE_I, 2); endsequence
  bus_answer_a: assert property (req_s |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("bus answer wrong");
  read_upper_a: assert property (!AVS_WAITREQUEST_O && AVS_READ_I |-> AVS_READDATA_O[31:16] == 16'h0000)
    else $error("read upper half not zero");
  trig_pulse_a: assert property (SPECIAL_EVENT_TRIG_O |=> !SPECIAL_EVENT_TRIG_O)
    else $error("trigger longer than one cycle");
  irq_cause_a: assert property (SPECIAL_EVENT_IRQ_O |-> SPECIAL_EVENT_TRIG_O || $past(SPECIAL_EVENT_TRIG_O))
    else $error("irq without trigger");
  oe_write_a: assert property ($changed(SYNC_OUTPUT_TWO_OE_N_O) |-> wrote_s)
    else $error("sync enable moved without write");
  duty_write_a: assert property ($changed(MASTER_DUTY_CYCLE_O) |-> wrote_s)
    else $error("master duty moved without write");
  count_step_a: assert property ($changed(MASTER_TIMEBASE_COUNTER_O) |-> MASTER_TIMEBASE_COUNTER_O == $past(MASTER_TIMEBASE_COUNTER_O) + 16'h0001 || MASTER_TIMEBASE_COUNTER_O == 16'h0000)
    else $error("counter jumped");
  wrap_zero_a: assert property (TIMEBASE_ROLLOVER_O |-> ##[0:2] MASTER_TIMEBASE_COUNTER_O == 16'h0000)
    else $error("rollover without zero count");
endmodule
bind pstc_top pstc_sva pstc_sva_i (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .SPECIAL_EVENT_TRIG_O(SPECIAL_EVENT_TRIG_O), .SPECIAL_EVENT_IRQ_O(SPECIAL_EVENT_IRQ_O),
  .SYNC_OUTPUT_TWO_OE_N_O(SYNC_OUTPUT_TWO_OE_N_O), .MASTER_TIMEBASE_COUNTER_O(MASTER_TIMEBASE_COUNTER_O),
  .TIMEBASE_ROLLOVER_O(TIMEBASE_ROLLOVER_O), .MASTER_DUTY_CYCLE_O(MASTER_DUTY_CYCLE_O));
`default_nettype wire

// File: verification/test_pstc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_pstc_top;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, chq;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [3:0] ev;
  logic [15:0] r, c;
  wire [31:0] rdd;
  wire wq, tg, irq, rov, chp, so, soe, pclr, mts, men, tk;
  wire [15:0] cnt, mdc, dsel, gd;
  wire [2:0] sy;
  int errors = 0, n_compared = 0, cyc = 0, nirq = 0, n, d, k, m;
  int pst [3] = '{0, 1, 15};
  int fb [4] = '{0, 1, 2, 0};
  logic [15:0] stab [4] = '{16'h0580, 16'h07A0, 16'h05B0, 16'h0700};
  logic [15:0] mdl [8] = '{16'h0, 16'h0, 16'hFFF8, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] msk [8] = '{16'h0FFF, 16'h7, 16'hFFFF, 16'hFFFF, 16'h83FF, 16'hFFFF, 16'h8108, 16'h0};
  pstc_top pstc_top_i (.CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'h3), .AVS_READDATA_O(rdd),
    .AVS_WAITREQUEST_O(wq), .EXT_SYNC_INPUT_ONE_I(sy[0]), .TRIG_GEN_OUTPUT_16_I(sy[1]),
    .TRIG_GEN_OUTPUT_17_I(sy[2]), .PEND_CLEAR_I(pclr), .GEN_DUTY_I(gd), .SYNC_OUTPUT_TWO_O(so),
    .SYNC_OUTPUT_TWO_OE_N_O(soe), .SPECIAL_EVENT_TRIG_O(tg), .SPECIAL_EVENT_IRQ_O(irq),
    .MASTER_TIMEBASE_COUNTER_O(cnt), .TIMEBASE_TICK_O(tk), .TIMEBASE_ROLLOVER_O(rov),
    .CHOP_CLOCK_O(chp), .MASTER_DUTY_CYCLE_O(mdc), .GEN_DUTY_SEL_O(dsel),
    .MASTER_TIMEBASE_SELECT_O(mts), .PWM_MODULE_ENABLE_O(men));
  pstc_far_side pstc_far_side_i (.clk_i(clk), .sync_o(sy), .pend_clear_o(pclr), .duty_o(gd));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    chq <= chp;
    ev <= {tk, chp & !chq, tg, rov};
    if (irq === 1'b1) nirq++;
    cyc++;
    if (cyc == 40000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input int i, input logic [15:0] v);
    @(posedge clk);
    adr <= 5'(i * 4);
    wd <= {16'h0000, v};
    rd <= !w;
    wr <= w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 50);
    rdat = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 50) errors++;
  endtask
  task automatic pend(input logic e);
    bus(0, 0, 16'h0);
    chk(rdat[12], e);
  endtask
  task automatic gap(input int s);
    n = 0;
    do @(posedge clk); while (ev[s] !== 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (ev[s] !== 1'b1 && n < 5000);
  endtask
  task automatic cfg(input logic [15:0] cc, dv, pr, ch);
    bus(1, 6, 16'h0000);
    bus(1, 0, cc);
    bus(1, 1, dv);
    bus(1, 2, pr);
    bus(1, 3, 16'h0004);
    bus(1, 4, ch);
    bus(1, 6, 16'h8008);
  endtask
  task automatic results();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(20473));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(0, i, 16'h0);
      chk(rdat, {16'h0, mdl[i]});
    end
    // module stays off while settings are scrambled
    repeat (3) begin
      for (int i = 0; i < 8; i++) begin
        r = 16'($urandom);
        if (i == 6) r[15] = 1'b0;
        bus(1, i, r);
        mdl[i] = r & msk[i];
      end
      pstc_far_side_i.park(1'b0, 16'($urandom));
      for (int i = 0; i < 8; i++) begin
        bus(0, i, 16'h0);
        chk(rdat, {16'h0, mdl[i]});
      end
      chk(mdc, mdl[5]);
      chk(dsel, mdl[6][8] ? mdl[5] : gd);
      chk({mts, men, soe}, {mdl[6][3], 1'b0, !mdl[0][8]});
    end
    for (int p = 0; p < 8; p++) begin
      d = (p == 7) ? 1 : (1 << p);
      cfg(16'h0400, 16'(p), 16'h0009, 16'h8003);
      gap(0);
      chk(n, 10 * d);
      gap(2);
      chk(n, 4 * d);
      gap(3);
      chk(n, d);
    end
    cfg(16'h0400, 16'h0, 16'h0009, 16'h0003);
    c[0] = chp;
    k = 0;
    repeat (40) @(posedge clk) k += (chp !== c[0]);
    chk(k, 0);
    for (int j = 0; j < 3; j++) begin
      c = 16'h0400 | 16'(pst[j]) | (j == 1 ? 16'h0000 : 16'h0800);
      cfg(c, 16'h0, 16'h0009, 16'h0);
      m = nirq;
      gap(1);
      chk(n, 10 * (pst[j] + 1));
      chk(nirq > m, c[11]);
    end
    pend(1'b1);
    bus(1, 0, c);
    pend(1'b0);
    gap(1);
    pend(1'b1);
    pstc_far_side_i.clr();
    pend(1'b0);
    for (int j = 0; j < 4; j++) begin
      c = stab[j];
      pstc_far_side_i.park(c[9], 16'h0);
      cfg(c, 16'h0, 16'h03FF, 16'h0);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (cnt < 16'h012C && n < 2000);
      pstc_far_side_i.fire(fb[j]);
      repeat (4) @(posedge clk);
      chk(cnt < 16'h0014, c[7]);
      chk({so, soe}, {c[9], 1'b0});
    end
    results();
  end
endmodule
`default_nettype wire
